/* include/tesf_defs.vh */
/*
 * Register offsets, field positions, reset values and timing figures of the
 * Type F transmit edge shaper.
 * Assumes it is included by bare name from the shaper's design files.
 */
`ifndef TESF_DEFS_VH
`define TESF_DEFS_VH

`define TESF_ADDR_W 8
`define TESF_OFS_CFG212 8'h36
`define TESF_OFS_LEN212 8'h37
`define TESF_OFS_RES424 8'h38
`define TESF_OFS_MTH424 8'h39
`define TESF_OFS_RES212 8'h40
`define TESF_OFS_MTH212 8'h41
`define TESF_OFS_CTRL 8'h42
`define TESF_OFS_STAT 8'h43

`define TESF_CFG_MASK 8'h77
`define TESF_LEN_MASK 8'h9f
`define TESF_CTRL_MASK 8'h03
`define TESF_FALL_MSB 7
`define TESF_FALL_LSB 4
`define TESF_RISE_MSB 3
`define TESF_RISE_LSB 0
`define TESF_TCF_MSB 6
`define TESF_TCF_LSB 4
`define TESF_TCR_MSB 2
`define TESF_TCR_LSB 0
`define TESF_LEN_DBL 7
`define TESF_LEN_MSB 4
`define TESF_LEN_LSB 0
`define TESF_CTRL_EN 0
`define TESF_CTRL_RATE 1

`define TESF_RST_CFG 8'h00
`define TESF_RST_LEN 8'h00
`define TESF_RST_RES 8'h00
`define TESF_RST_MTH 8'h11
`define TESF_RST_CTRL 8'h00

`define TESF_STY_LIN1 4'h1
`define TESF_STY_LIN3 4'h3
`define TESF_STY_LUT 4'h4
`define TESF_STY_LUT_ADJ 4'h5
`define TESF_STY_LUT_RAW 4'h6

`define TESF_AMP_FULL 8'hff
`define TESF_AMP_OFF 8'h00

`define TESF_CLK_KHZ 20000
`define TESF_CARRIER_KHZ 13560

`endif

/* rtl/tesf_carrier_div.v */
/*
 * Carrier-rate divider: a fractional accumulator that turns the system clock
 * into one-cycle enables at the carrier rate, and a transition-state enable
 * that is every carrier tick, or every second one when doubling is on.
 * Assumes the carrier is slower than the system clock.
 */
`timescale 1ns/100ps
`include "tesf_defs.vh"

module tesf_carrier_div #(
	parameter CLK_KHZ = `TESF_CLK_KHZ,
	parameter CARRIER_KHZ = `TESF_CARRIER_KHZ
) (
	input wire clk,
	input wire rst_n,
	input wire dbl,
	output reg state_tick
);

	// Rates are given in kHz, so sixteen bits hold them.
	localparam [31:0] INC_W = CARRIER_KHZ;
	localparam [31:0] MODV_W = CLK_KHZ;
	localparam [15:0] INC = INC_W[15:0];
	localparam [15:0] MODV = MODV_W[15:0];

	reg [15:0] acc_r;
	reg half_r;
	wire [16:0] sum = {1'b0, acc_r} + {1'b0, INC};
	wire wrap = (sum >= {1'b0, MODV});

	////////////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		if (!rst_n) begin
			acc_r <= 16'h0000;
			half_r <= 1'b0;
			state_tick <= 1'b0;
		end else begin
			if (wrap)
				acc_r <= sum[15:0] - MODV;
			else
				acc_r <= sum[15:0];
			// A doubled state waits for two carrier ticks.
			if (wrap)
				half_r <= dbl ? ~half_r : 1'b0;
			state_tick <= wrap & (~dbl | half_r);
		end
	end

endmodule // tesf_carrier_div

/* rtl/tesf_edge_gen.v */
/*
 * Combinational edge shape: the amplitude for one transition state of a
 * falling or rising edge from style code, style field, step, length,
 * residual level and transmitter supply measurement.
 * Assumes step runs 1..len and len is not zero.
 */
`timescale 1ns/100ps
`include "tesf_defs.vh"

module tesf_edge_gen (
	input wire [3:0] style,
	input wire [2:0] cfg,
	input wire [4:0] step,
	input wire [4:0] len,
	input wire rising,
	input wire [7:0] residual,
	input wire [7:0] supply,
	output reg [7:0] amp,
	output wire reserved
);

	// Four fixed progress curves of eight points each.
	function [7:0] lut_val;
		input [1:0] tbl;
		input [2:0] idx;
		reg [63:0] row;
		begin
			case (tbl)
			2'd0: row = 64'h2040_6080_a0c0_e0ff;
			2'd1: row = 64'h0818_3860_98c8_e8ff;
			2'd2: row = 64'h4070_98b8_d0e4_f4ff;
			2'd3: row = 64'h0408_1020_4070_b0ff;
			default: row = 64'h2040_6080_a0c0_e0ff;
			endcase
			lut_val = row[(7 - idx) * 8 +: 8];
		end
	endfunction

	// Piecewise line through knees lifted by the time constant.
	function [7:0] seg_val;
		input [1:0] segs;
		input [2:0] tc;
		input [7:0] p;
		reg [8:0] k1;
		reg [8:0] k2;
		reg [16:0] t;
		begin
			k1 = 9'd85 + {2'b00, tc, 4'h0};
			k2 = 9'd170 + {3'b000, tc, 3'h0};
			t = 17'h00000;
			if (segs == 2'd2) begin
				k1 = 9'd128 + {2'b00, tc, 4'h0};
				if (p < 8'd128)
					t = ({8'h00, p} * k1) >> 7;
				else
					t = {8'h00, k1} + ((({9'h000, p} - 17'd128)
						* (17'd255 - {8'h00, k1})) >> 7);
			end else if (segs == 2'd3) begin
				if (p < 8'd85)
					t = ({8'h00, p} * k1) / 17'd85;
				else if (p < 8'd170)
					t = {8'h00, k1} + ((({9'h000, p} - 17'd85)
						* ({8'h00, k2} - {8'h00, k1})) / 17'd85);
				else
					t = {8'h00, k2} + ((({9'h000, p} - 17'd170)
						* (17'd255 - {8'h00, k2})) / 17'd85);
			end else
				t = {9'h000, p};
			seg_val = (t > 17'd255) ? 8'hff : t[7:0];
		end
	endfunction

	reg [12:0] prog;
	reg [7:0] p;
	reg [7:0] f;
	reg [15:0] adj;
	reg [7:0] span;
	reg [16:0] d;

	assign reserved = (style < `TESF_STY_LIN1) |
		(style > `TESF_STY_LUT_RAW);

	always @* begin
		// A length cleared in mid-edge must not divide by zero.
		if (len == 5'd0)
			prog = 13'h00ff;
		else
			prog = ({8'h00, step} * 13'd255) / {8'h00, len};
		p = prog[7:0];
		adj = 16'h0000;
		case (style)
		4'h2: f = seg_val(2'd2, cfg, p);
		4'h3: f = seg_val(2'd3, cfg, p);
		`TESF_STY_LUT: f = lut_val(cfg[1:0] | {2{cfg[2]}}, p[7:5]);
		`TESF_STY_LUT_ADJ: begin
			// Shape stretched by supply, then corrected toward the line.
			adj = {8'h00, lut_val(cfg[1:0] | {2{cfg[2]}}, p[7:5])} *
				{8'h00, supply};
			f = {1'b0, adj[15:9]} + {1'b0, p[7:1]};
		end
		`TESF_STY_LUT_RAW: begin
			adj = {8'h00, lut_val(cfg[1:0] | {2{cfg[2]}}, p[7:5])} *
				{8'h00, supply};
			f = adj[15:8];
		end
		default: f = p;
		endcase
		if (step == len)
			f = 8'hff;
		span = `TESF_AMP_FULL - residual;
		d = ({9'h000, span} * {9'h000, f} + {9'h000, span}) >> 8;
		if (rising)
			amp = residual + d[7:0];
		else
			amp = `TESF_AMP_FULL - d[7:0];
	end

endmodule // tesf_edge_gen

/* rtl/tesf_shaper.v */
/*
 * Type F transmit edge shaper: register file and the state machine that
 * steps the transmitter amplitude between full carrier and the residual
 * level on each modulation edge.
 * Assumes a 20 MHz clock, software on a plain strobe port, and a modulation
 * request level from the encoder that is synchronous to the clock.
 */
// Design decision made here: strobed register access.
// What this block does
// - The 424k residual setting is an 8-bit linear level, 0x00 off, 0xff full.
// - The falling nibble in bits 7:4 picks the method; 1..3 are linear segments.
// - The rising nibble in bits 3:0 uses the same codes: 1..3 linear, 4..6 table.
// - Code 4 uses the table as is, 5 adapts to supply with correction, 6 without.
// - For a linear falling style, config bits 6:4 are the fall time constant.
// - For a linear rising style, config bits 2:0 are the rise time constant.
// - For a table style, the edge's config field selects table 0 to 3.
// - Length bit 7 makes every transition state last two carrier cycles.
// - Length bits 4:0 give the state count of both edges; bits 6:5 reserved.
`timescale 1ns/100ps
`include "tesf_defs.vh"

module tesf_shaper #(
	parameter CLK_KHZ = `TESF_CLK_KHZ,
	parameter CARRIER_KHZ = `TESF_CARRIER_KHZ
) (
	input wire CLOCK,
	input wire RST_N,
	input wire [7:0] REG_ADDR,
	input wire [7:0] REG_WDATA,
	input wire REG_WR,
	input wire REG_RD,
	output reg [7:0] REG_RDATA,
	input wire MOD_REQ,
	input wire [7:0] TX_SUPPLY,
	output reg [7:0] AMPLITUDE,
	output reg EDGE_BUSY
);

	localparam [1:0] ST_HIGH = 2'd0;
	localparam [1:0] ST_FALL = 2'd1;
	localparam [1:0] ST_LOW = 2'd2;
	localparam [1:0] ST_RISE = 2'd3;

	reg [7:0] cfg212_r;
	reg [7:0] len212_r;
	reg [7:0] res424_r;
	reg [7:0] mth424_r;
	reg [7:0] res212_r;
	reg [7:0] mth212_r;
	reg [7:0] ctrl_r;
	reg [1:0] st_r;
	reg [1:0] st_nxt;
	reg [4:0] step_r;
	reg [4:0] step_nxt;
	reg [7:0] amp_nxt;
	reg rsv_r;

	wire tick;
	wire [7:0] gen_amp;
	wire gen_rsv;

	////////////////////////////////////////////////////////////////////////
	// Active method and residual, chosen by the rate bit; config and length always come from the 212k registers.

	wire rate424 = ctrl_r[`TESF_CTRL_RATE];
	wire enable = ctrl_r[`TESF_CTRL_EN];
	wire [7:0] method = rate424 ? mth424_r : mth212_r;
	wire [7:0] residual = rate424 ? res424_r : res212_r;
	wire rising = (st_r == ST_RISE);
	wire [3:0] style = rising ?
		method[`TESF_RISE_MSB:`TESF_RISE_LSB] :
		method[`TESF_FALL_MSB:`TESF_FALL_LSB];
	wire [2:0] cfg = rising ?
		cfg212_r[`TESF_TCR_MSB:`TESF_TCR_LSB] :
		cfg212_r[`TESF_TCF_MSB:`TESF_TCF_LSB];
	wire [4:0] len = len212_r[`TESF_LEN_MSB:`TESF_LEN_LSB];
	wire [4:0] step_up = step_r + 5'd1;

	tesf_carrier_div #(
		.CLK_KHZ(CLK_KHZ),
		.CARRIER_KHZ(CARRIER_KHZ)
	) u_div (
		.clk(CLOCK),
		.rst_n(RST_N),
		.dbl(len212_r[`TESF_LEN_DBL]),
		.state_tick(tick)
	);

	tesf_edge_gen u_gen (
		.style(style),
		.cfg(cfg),
		.step(step_up),
		.len(len),
		.rising(rising),
		.residual(residual),
		.supply(TX_SUPPLY),
		.amp(gen_amp),
		.reserved(gen_rsv)
	);

	////////////////////////////////////////////////////////////////////////
	// Edge sequencer. An edge always runs to its end before the opposite
	// one starts, so a short pulse on the request never leaves a half step.

	always @* begin
		st_nxt = st_r;
		step_nxt = step_r;
		amp_nxt = AMPLITUDE;
		case (st_r)
		ST_HIGH: begin
			amp_nxt = `TESF_AMP_FULL;
			step_nxt = 5'd0;
			if (enable && MOD_REQ) begin
				if (len == 5'd0) begin
					st_nxt = ST_LOW;
					amp_nxt = residual;
				end else
					st_nxt = ST_FALL;
			end
		end
		ST_FALL: begin
			if (tick) begin
				amp_nxt = gen_amp;
				step_nxt = step_up;
				if (step_up >= len) begin
					st_nxt = ST_LOW;
					step_nxt = 5'd0;
				end
			end
		end
		ST_LOW: begin
			amp_nxt = residual;
			step_nxt = 5'd0;
			if (!MOD_REQ || !enable) begin
				if (len == 5'd0) begin
					st_nxt = ST_HIGH;
					amp_nxt = `TESF_AMP_FULL;
				end else
					st_nxt = ST_RISE;
			end
		end
		ST_RISE: begin
			if (tick) begin
				amp_nxt = gen_amp;
				step_nxt = step_up;
				if (step_up >= len) begin
					st_nxt = ST_HIGH;
					step_nxt = 5'd0;
				end
			end
		end
		default: begin
			st_nxt = ST_HIGH;
			step_nxt = 5'd0;
			amp_nxt = `TESF_AMP_FULL;
		end
		endcase
	end

	always @(posedge CLOCK) begin
		if (!RST_N) begin
			st_r <= ST_HIGH;
			step_r <= 5'd0;
			AMPLITUDE <= `TESF_AMP_FULL;
			EDGE_BUSY <= 1'b0;
			rsv_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			step_r <= step_nxt;
			AMPLITUDE <= amp_nxt;
			EDGE_BUSY <= (st_nxt == ST_FALL) || (st_nxt == ST_RISE);
			// Sticky until written; a new hit in the clearing cycle wins.
			if ((st_r == ST_FALL || st_r == ST_RISE) && gen_rsv)
				rsv_r <= 1'b1;
			else if (REG_WR && REG_ADDR == `TESF_OFS_STAT && REG_WDATA[1])
				rsv_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register file. Reserved bits are not stored and read as zero.

	always @(posedge CLOCK) begin
		if (!RST_N) begin
			cfg212_r <= `TESF_RST_CFG;
			len212_r <= `TESF_RST_LEN;
			res424_r <= `TESF_RST_RES;
			mth424_r <= `TESF_RST_MTH;
			res212_r <= `TESF_RST_RES;
			mth212_r <= `TESF_RST_MTH;
			ctrl_r <= `TESF_RST_CTRL;
		end else if (REG_WR) begin
			case (REG_ADDR)
			`TESF_OFS_CFG212: cfg212_r <= REG_WDATA & `TESF_CFG_MASK;
			`TESF_OFS_LEN212: len212_r <= REG_WDATA & `TESF_LEN_MASK;
			`TESF_OFS_RES424: res424_r <= REG_WDATA;
			`TESF_OFS_MTH424: mth424_r <= REG_WDATA;
			`TESF_OFS_RES212: res212_r <= REG_WDATA;
			`TESF_OFS_MTH212: mth212_r <= REG_WDATA;
			`TESF_OFS_CTRL: ctrl_r <= REG_WDATA & `TESF_CTRL_MASK;
			default: ctrl_r <= ctrl_r;
			endcase
		end
	end

	always @(posedge CLOCK) begin
		if (!RST_N)
			REG_RDATA <= 8'h00;
		else if (REG_RD) begin
			case (REG_ADDR)
			`TESF_OFS_CFG212: REG_RDATA <= cfg212_r;
			`TESF_OFS_LEN212: REG_RDATA <= len212_r;
			`TESF_OFS_RES424: REG_RDATA <= res424_r;
			`TESF_OFS_MTH424: REG_RDATA <= mth424_r;
			`TESF_OFS_RES212: REG_RDATA <= res212_r;
			`TESF_OFS_MTH212: REG_RDATA <= mth212_r;
			`TESF_OFS_CTRL: REG_RDATA <= ctrl_r;
			`TESF_OFS_STAT: REG_RDATA <= {3'b000, step_r[2:0], rsv_r,
				EDGE_BUSY};
			default: REG_RDATA <= 8'h00;
			endcase
		end else
			REG_RDATA <= 8'h00;
	end

endmodule // tesf_shaper

/* test/tb_top.sv */
/* Self-checking bench for the Type F edge shaper.
   Assumes the checker is bound and the driver model sits on AMPLITUDE. */
`timescale 1ns/100ps
module tb_top;
	reg clock = 1'b0;
	reg rst_n = 1'b0;
	reg [7:0] addr = 8'h00;
	reg [7:0] wdata = 8'h00;
	reg wr = 1'b0;
	reg rd = 1'b0;
	reg mod_req = 1'b0;
	reg [7:0] supply = 8'hc0;
	wire [7:0] rdata;
	wire [7:0] amp;
	wire busy;
	wire [7:0] level;
	wire [15:0] moves;
	integer failures = 0;
	integer checks_done = 0;
	integer i;
	always #25 clock = ~clock;
	tesf_shaper dut_u (.CLOCK(clock), .RST_N(rst_n), .REG_ADDR(addr),
		.REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
		.MOD_REQ(mod_req), .TX_SUPPLY(supply), .AMPLITUDE(amp),
		.EDGE_BUSY(busy));
	tesf_tx_drv drv_u (.clk(clock), .amp(amp), .level_r(level),
		.moves_r(moves));
	////////////////////////////////////////////////////////////////////////
	task check(input [15:0] seen, input [15:0] want);
		begin
			checks_done = checks_done + 1;
			if (seen !== want) begin
				failures = failures + 1;
				$display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
			end
		end
	endtask
	task final_report;
		begin
			$display("checks=%0d failures=%0d", checks_done, failures);
			if (failures == 0 && checks_done > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask
	task rreg(input [7:0] a, input [7:0] want);
		begin
			addr <= a;
			rd <= 1'b1;
			@(posedge clock);
			rd <= 1'b0;
			@(negedge clock);
			check(rdata, want);
			@(posedge clock);
		end
	endtask
	task wrd(input [7:0] a, input [7:0] d, input [7:0] want);
		begin
			addr <= a;
			wdata <= d;
			wr <= 1'b1;
			@(posedge clock);
			wr <= 1'b0;
			rreg(a, want);
		end
	endtask
	// Ticks come one or two clocks apart, so the edge length has a window.
	task run(input fall, input [7:0] want, input integer t);
		integer n;
		reg [7:0] last;
		reg [15:0] m0;
		begin
			n = 0;
			m0 = moves;
			last = fall ? 8'hff : 8'h00;
			@(posedge clock);
			@(negedge clock);
			while (busy === 1'b1 && n < 200) begin
				check(fall ? amp <= last : amp >= last, 1'b1);
				last = amp;
				n = n + 1;
				@(negedge clock);
			end
			check(amp, want);
			check(n >= t - 1 && n <= 2 * t + 1, 1'b1);
			check(moves != m0, 1'b1);
			@(posedge clock);
		end
	endtask
	task t_edge(input [7:0] len, input [7:0] sty, input [7:0] res);
		begin
			wrd(8'h37, len, len & 8'h9f);
			wrd(8'h39, sty, sty);
			wrd(8'h38, res, res);
			mod_req <= 1'b1;
			run(1'b1, res, len[4:0] * (len[7] ? 2 : 1));
			mod_req <= 1'b0;
			run(1'b0, 8'hff, len[4:0] * (len[7] ? 2 : 1));
		end
	endtask
	task t_regs;
		begin
			rreg(8'h36, 8'h00);
			rreg(8'h37, 8'h00);
			rreg(8'h38, 8'h00);
			rreg(8'h39, 8'h11);
			rreg(8'h40, 8'h00);
			rreg(8'h41, 8'h11);
			rreg(8'h42, 8'h00);
			rreg(8'h43, 8'h00);
			rreg(8'h80, 8'h00);
			wrd(8'h36, 8'hff, 8'h77);
			wrd(8'h37, 8'hff, 8'h9f);
			wrd(8'h80, 8'h5a, 8'h00);
			for (i = 1; i <= 6; i = i + 1)
				wrd(8'h39, {i[3:0], i[3:0]},
					{i[3:0], i[3:0]});
			wrd(8'h42, 8'hff, 8'h03);
		end
	endtask
	task t_levels;
		begin
			wrd(8'h37, 8'h00, 8'h00);
			wrd(8'h38, 8'hff, 8'hff);
			mod_req <= 1'b1;
			repeat (2) @(posedge clock);
			@(negedge clock);
			check({busy, amp}, 9'h0ff);
			wrd(8'h38, 8'h00, 8'h00);
			@(negedge clock);
			check({busy, amp}, 9'h000);
			@(posedge clock);
			mod_req <= 1'b0;
			repeat (2) @(posedge clock);
			@(negedge clock);
			check({busy, amp}, 9'h0ff);
			@(posedge clock);
		end
	endtask
	// The slow rate uses its own residual; 0x38 still holds 0x00 here.
	// Clearing the enable in the low state must start a rise on its own.
	task t_rate212;
		begin
			wrd(8'h37, 8'h08, 8'h08);
			wrd(8'h40, 8'h50, 8'h50);
			wrd(8'h41, 8'h22, 8'h22);
			wrd(8'h42, 8'h01, 8'h01);
			mod_req <= 1'b1;
			run(1'b1, 8'h50, 8);
			wrd(8'h42, 8'h00, 8'h00);
			run(1'b0, 8'hff, 8);
			repeat (3) @(posedge clock);
			@(negedge clock);
			check({busy, amp}, 9'h0ff);
			@(posedge clock);
			mod_req <= 1'b0;
			wrd(8'h42, 8'h03, 8'h03);
		end
	endtask
	task t_styles;
		begin
			wrd(8'h36, 8'h32, 8'h32);
			for (i = 1; i <= 6; i = i + 1)
				t_edge(8'h04, {i[3:0], i[3:0]}, 8'h20);
			rreg(8'h43, 8'h00);
			t_edge(8'h84, 8'h70, 8'h20);
			rreg(8'h43, 8'h02);
			wrd(8'h43, 8'h02, 8'h00);
			supply <= 8'h40;
			t_edge(8'hff, 8'h61, 8'h00);
			supply <= 8'hc0;
		end
	endtask
	// Reset in the middle of a long fall must bring back full carrier and
	// the register defaults.
	task t_reset;
		begin
			mod_req <= 1'b1;
			repeat (4) @(posedge clock);
			@(negedge clock);
			check(busy, 1'b1);
			@(posedge clock);
			rst_n <= 1'b0;
			mod_req <= 1'b0;
			repeat (3) @(posedge clock);
			@(negedge clock);
			check({busy, amp}, 9'h0ff);
			@(posedge clock);
			rst_n <= 1'b1;
			rreg(8'h37, 8'h00);
			rreg(8'h39, 8'h11);
			rreg(8'h40, 8'h00);
			rreg(8'h42, 8'h00);
			@(negedge clock);
			check({busy, amp}, 9'h0ff);
			@(posedge clock);
		end
	endtask
	initial begin
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		t_regs;
		t_levels;
		t_rate212;
		t_styles;
		t_reset;
		final_report;
	end
	// The tests need well under a thousand clocks; twenty thousand means a hang.
	initial begin
		#1000000;
		failures = failures + 1;
		final_report;
	end
endmodule // tb_top

/* test/tesf_sva.sv */
/* Port checker for the Type F edge shaper, bound to its top module.
   Assumes one clock domain and the synchronous active-low reset. */
`timescale 1ns/100ps
module tesf_sva (
	input wire CLOCK,
	input wire RST_N,
	input wire [7:0] REG_ADDR,
	input wire [7:0] REG_WDATA,
	input wire REG_WR,
	input wire REG_RD,
	input wire [7:0] REG_RDATA,
	input wire MOD_REQ,
	input wire [7:0] AMPLITUDE,
	input wire EDGE_BUSY
);
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RST_N);
	property p_rd_idle;
		!REG_RD |=> REG_RDATA == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("stray rdata");
	property p_res;
		REG_WR && REG_ADDR == 8'h38 ##1 REG_RD && REG_ADDR == 8'h38
			|=> REG_RDATA == $past(REG_WDATA, 2);
	endproperty
	a_res: assert property (p_res)
		else $error("residual readback");
	property p_cfg;
		REG_WR && REG_ADDR == 8'h36 ##1 REG_RD && REG_ADDR == 8'h36
			|=> REG_RDATA == ($past(REG_WDATA, 2) & 8'h77);
	endproperty
	a_cfg: assert property (p_cfg)
		else $error("config readback");
	property p_len;
		REG_WR && REG_ADDR == 8'h37 ##1 REG_RD && REG_ADDR == 8'h37
			|=> REG_RDATA == ($past(REG_WDATA, 2) & 8'h9f);
	endproperty
	a_len: assert property (p_len)
		else $error("length readback");
	property p_mth;
		REG_WR && REG_ADDR == 8'h39 ##1 REG_RD && REG_ADDR == 8'h39
			|=> REG_RDATA == $past(REG_WDATA, 2);
	endproperty
	a_mth: assert property (p_mth)
		else $error("method readback");
	property p_bound;
		$rose(EDGE_BUSY) |-> ##[1:140] !EDGE_BUSY;
	endproperty
	a_bound: assert property (p_bound)
		else $error("edge too long");
	property p_idle;
		!EDGE_BUSY && !$past(EDGE_BUSY) && !$past(MOD_REQ)
			&& $past(AMPLITUDE) == 8'hff |-> AMPLITUDE == 8'hff;
	endproperty
	a_idle: assert property (p_idle)
		else $error("full level left");
	// An edge taken with the request low can only be a rise, so its first
	// step never drops below the residual level it starts from.
	property p_start;
		$rose(EDGE_BUSY) && !$past(MOD_REQ)
			|=> AMPLITUDE >= $past(AMPLITUDE);
	endproperty
	a_start: assert property (p_start)
		else $error("rise went down");
endmodule // tesf_sva

bind tesf_shaper tesf_sva chk_u (.CLOCK(CLOCK), .RST_N(RST_N),
	.REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
	.REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .MOD_REQ(MOD_REQ),
	.AMPLITUDE(AMPLITUDE), .EDGE_BUSY(EDGE_BUSY));

/* test/tesf_tx_drv.sv */
/* Behavioural transmitter driver stage fed by the shaper amplitude.
   Assumes the amplitude is registered on the same clock. */
`timescale 1ns/100ps
module tesf_tx_drv (
	input wire clk,
	input wire [7:0] amp,
	output reg [7:0] level_r,
	output reg [15:0] moves_r
);
	initial begin
		level_r = 8'hff;
		moves_r = 16'h0000;
	end
	// The stage lags one clock and counts steps, so a stuck shaper shows.
	always @(posedge clk) begin
		if (level_r !== amp) begin
			moves_r <= moves_r + 16'h0001;
		end
		level_r <= amp;
	end
endmodule // tesf_tx_drv
